// ---- rtl/slfa_pkg.sv ----
package slfa_pkg;

   // register map
   localparam logic [7:0] CTRL_OFS       = 8'h00;
   localparam logic [7:0] LOCK_VIEW_OFS  = 8'h04;

   // control register field positions
   localparam int         EN_BIT         = 0;
   localparam int         LOCKSET_BIT    = 3;
   localparam int         REENABLE_BIT   = 4;
   localparam int         RWW_BUSY_BIT   = 6;
   localparam int         IRQ_EN_BIT     = 7;

   // command patterns on control bits 5..0
   localparam logic [5:0] CMD_LOCK_SET   = 6'h09;
   localparam logic [5:0] CMD_RWW_REEN   = 6'h11;
   localparam logic [5:0] MODE_RESET     = 6'h00;

   // timed acceptance windows, cycles after the control write
   localparam logic [2:0] STORE_WIN      = 3'h4;
   localparam logic [2:0] LOAD_WIN       = 3'h3;

   // address pointer values for readout
   localparam logic [15:0] Z_FUSE_LOW    = 16'h0000;
   localparam logic [15:0] Z_LOCK        = 16'h0001;
   localparam logic [15:0] Z_FUSE_EXT    = 16'h0002;
   localparam logic [15:0] Z_FUSE_HIGH   = 16'h0003;

   // lock bits after power-on, all unprogrammed
   localparam logic [5:0] LOCK_RESET     = 6'h3F;
   localparam logic [1:0] UNUSED_HI      = 2'h3;
   localparam logic [3:0] UNUSED_EXT     = 4'hF;

   // axi responses
   localparam logic [1:0] RESP_OKAY      = 2'h0;
   localparam logic [1:0] RESP_SLVERR    = 2'h2;

   // flash write time
   localparam int         CLK_MHZ        = 200;
   localparam int         PROG_MIN_NS    = 3_700_000;
   localparam int         PROG_MAX_NS    = 4_500_000;
   localparam int         PROG_CYCLES    = (PROG_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int         PROG_MAX_CYC   = (PROG_MAX_NS * CLK_MHZ) / 1000;

endpackage

// ---- rtl/slfa_lock_prog.sv ----
`timescale 1ns/1ps
module slfa_lock_prog #(
   parameter int PROG_CYCLES = slfa_pkg::PROG_CYCLES
) (
   input  wire logic       core_clk,
   input  wire logic       por_n,
   input  wire logic       start,
   input  wire logic [5:0] data,
   output logic            busy,
   output logic [5:0]      lock_bits
);
   localparam int CW = $clog2(PROG_CYCLES + 1);

   logic          busy_reg;
   logic          busy_next;
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic [5:0]    lock_reg;
   logic [5:0]    lock_next;
   logic [5:0]    pend_reg;
   logic [5:0]    pend_next;

   always_comb begin
      busy_next = busy_reg;
      cnt_next  = cnt_reg;
      lock_next = lock_reg;
      pend_next = pend_reg;
      if (start && !busy_reg) begin
         busy_next = 1'b1;
         cnt_next  = CW'(PROG_CYCLES - 1);
         pend_next = data;
      end else if (busy_reg) begin
         if (cnt_reg == '0) begin
            busy_next = 1'b0;
            lock_next = lock_reg & pend_reg;
         end else begin
            cnt_next = cnt_reg - 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge por_n) begin
      if (!por_n) begin
         busy_reg <= 1'b0;
         cnt_reg  <= '0;
         lock_reg <= slfa_pkg::LOCK_RESET;
         pend_reg <= slfa_pkg::LOCK_RESET;
      end else begin
         busy_reg <= busy_next;
         cnt_reg  <= cnt_next;
         lock_reg <= lock_next;
         pend_reg <= pend_next;
      end
   end

   assign busy      = busy_reg;
   assign lock_bits = lock_reg;

   lock_only_program_a: assert property (@(posedge core_clk) disable iff (!por_n)
      (lock_reg & ~$past(lock_reg)) == 6'h00)
      else $error("lock bit returned to unprogrammed");

   prog_duration_a: assert property (@(posedge core_clk) disable iff (!por_n)
      cnt_reg <= CW'(PROG_CYCLES - 1))
      else $error("write timer beyond programming time");

endmodule

// ---- rtl/slfa_top.sv ----
`timescale 1ns/1ps
module slfa_top #(
   parameter int PROG_CYCLES = slfa_pkg::PROG_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic        por_n,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        insn_store_pgm,
   input  wire logic        insn_load_pgm,
   input  wire logic [15:0] insn_zptr,
   input  wire logic [7:0]  low_working_register,
   input  wire logic        eeprom_write_busy,
   input  wire logic        rww_prog_busy,
   input  wire logic [7:0]  fuse_low_byte,
   input  wire logic [7:0]  fuse_high_byte,
   input  wire logic [3:0]  extended_fuse_byte,
   input  wire logic [7:0]  pm_rd_data,
   output logic [15:0]      pm_rd_addr,
   output logic             lpm_valid,
   output logic [7:0]       lpm_data,
   output logic             irq_req,
   output logic [5:0]       lock_bits
);
   logic        awf_reg,  awf_next,  wf_reg,  wf_next;
   logic [7:0]  awa_reg,  awa_next;
   logic [7:0]  wd_reg,   wd_next;
   logic        wst_reg,  wst_next;
   logic        bv_reg,   bv_next,   rv_reg,  rv_next;
   logic [1:0]  br_reg,   br_next,   rr_reg,  rr_next;
   logic [31:0] rd_reg,   rd_next;
   logic [5:0]  mode_reg, mode_next;
   logic [2:0]  win_reg,  win_next;
   logic        rwwb_reg, rwwb_next;
   logic        irqen_reg, irqen_next;
   logic        irq_reg,  irq_next;
   logic        lv_reg,   lv_next,   pend_reg, pend_next;
   logic [7:0]  ld_reg,   ld_next;
   logic [15:0] pa_reg,   pa_next;
   logic        start,    prog_busy, en_vis, do_write, ctrl_wr, special_hit;
   logic [7:0]  ctrl_view, sel_byte;

   slfa_lock_prog #(
      .PROG_CYCLES (PROG_CYCLES)
   ) u_prog (
      .core_clk  (core_clk),
      .por_n     (por_n),
      .start     (start),
      .data      (low_working_register[5:0]),
      .busy      (prog_busy),
      .lock_bits (lock_bits)
   );

   // enable reads set until write finishes
   assign en_vis   = mode_reg[slfa_pkg::EN_BIT] | prog_busy;
   assign ctrl_view = {irqen_reg, rwwb_reg, 1'b0, mode_reg[4:1], en_vis};
   assign do_write = awf_reg && wf_reg && !bv_reg;
   assign ctrl_wr  = do_write && (awa_reg == slfa_pkg::CTRL_OFS) && wst_reg;

   always_comb begin
      unique case (insn_zptr)
         slfa_pkg::Z_FUSE_LOW:  sel_byte = fuse_low_byte;
         slfa_pkg::Z_LOCK:      sel_byte = {slfa_pkg::UNUSED_HI, lock_bits};
         slfa_pkg::Z_FUSE_EXT:  sel_byte = {slfa_pkg::UNUSED_EXT, extended_fuse_byte};
         slfa_pkg::Z_FUSE_HIGH: sel_byte = fuse_high_byte;
         default:               sel_byte = 8'hFF;
      endcase
   end

   assign special_hit = insn_load_pgm && (mode_reg == slfa_pkg::CMD_LOCK_SET) && (win_reg >= 3'h2)
                        && !eeprom_write_busy && !ctrl_wr;
   assign start = insn_store_pgm && (mode_reg == slfa_pkg::CMD_LOCK_SET) && (win_reg != 3'h0)
                  && !eeprom_write_busy && !prog_busy && !ctrl_wr;

   always_comb begin
      awf_next = awf_reg;
      awa_next = awa_reg;
      wf_next  = wf_reg;
      wd_next  = wd_reg;
      wst_next = wst_reg;
      bv_next  = bv_reg;
      br_next  = br_reg;
      rv_next  = rv_reg;
      rr_next  = rr_reg;
      rd_next  = rd_reg;
      if (s_axi_awvalid && !awf_reg) begin
         awf_next = 1'b1;
         awa_next = {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !wf_reg) begin
         wf_next  = 1'b1;
         wd_next  = s_axi_wdata[7:0];
         wst_next = s_axi_wstrb[0];
      end
      if (do_write) begin
         awf_next = 1'b0;
         wf_next  = 1'b0;
         bv_next  = 1'b1;
         br_next  = (awa_reg == slfa_pkg::CTRL_OFS || awa_reg == slfa_pkg::LOCK_VIEW_OFS) ?
                    slfa_pkg::RESP_OKAY : slfa_pkg::RESP_SLVERR;
      end
      if (bv_reg && s_axi_bready) begin
         bv_next = 1'b0;
      end
      if (s_axi_arvalid && !rv_reg) begin
         rv_next = 1'b1;
         rr_next = slfa_pkg::RESP_OKAY;
         unique case ({s_axi_araddr[7:2], 2'b00})
            slfa_pkg::CTRL_OFS:      rd_next = {24'h000000, ctrl_view};
            slfa_pkg::LOCK_VIEW_OFS: rd_next = {24'h000000, slfa_pkg::UNUSED_HI, lock_bits};
            default: begin
               rd_next = 32'h00000000;
               rr_next = slfa_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rv_reg && s_axi_rready) begin
         rv_next = 1'b0;
      end
   end

   always_comb begin
      mode_next  = mode_reg;
      win_next   = win_reg;
      irqen_next = irqen_reg;
      rwwb_next  = rwwb_reg;
      lv_next    = 1'b0;
      ld_next    = ld_reg;
      pa_next    = pa_reg;
      pend_next  = 1'b0;
      if (win_reg != 3'h0) begin
         win_next = win_reg - 3'h1;
         if (win_reg == 3'h1) begin
            mode_next = slfa_pkg::MODE_RESET;
         end
      end
      if (start) begin
         // lock write leaves rww flag alone
         mode_next = slfa_pkg::MODE_RESET;
         win_next  = 3'h0;
      end else if (insn_store_pgm && (mode_reg == slfa_pkg::CMD_RWW_REEN) && (win_reg != 3'h0)
                   && !eeprom_write_busy && !ctrl_wr) begin
         rwwb_next = 1'b0;
         mode_next = slfa_pkg::MODE_RESET;
         win_next  = 3'h0;
      end
      if (special_hit) begin
         ld_next   = sel_byte;
         lv_next   = 1'b1;
         mode_next = slfa_pkg::MODE_RESET;
         win_next  = 3'h0;
      end else if (insn_load_pgm) begin
         pa_next   = insn_zptr;
         pend_next = 1'b1;
      end
      if (pend_reg) begin
         ld_next = pm_rd_data;
         lv_next = 1'b1;
      end
      if (ctrl_wr) begin
         irqen_next = wd_reg[slfa_pkg::IRQ_EN_BIT];
         if (wd_reg[slfa_pkg::EN_BIT] && !prog_busy) begin
            mode_next = wd_reg[5:0];
            win_next  = slfa_pkg::STORE_WIN;
         end
      end
      if (rww_prog_busy) begin
         rwwb_next = 1'b1;
      end
   end

   assign irq_next = irqen_reg & ~en_vis;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         awf_reg   <= 1'b0;
         awa_reg   <= 8'h00;
         wf_reg    <= 1'b0;
         wd_reg    <= 8'h00;
         wst_reg   <= 1'b0;
         bv_reg    <= 1'b0;
         br_reg    <= slfa_pkg::RESP_OKAY;
         rv_reg    <= 1'b0;
         rr_reg    <= slfa_pkg::RESP_OKAY;
         rd_reg    <= 32'h00000000;
         mode_reg  <= slfa_pkg::MODE_RESET;
         win_reg   <= 3'h0;
         rwwb_reg  <= 1'b0;
         irqen_reg <= 1'b0;
         irq_reg   <= 1'b0;
         lv_reg    <= 1'b0;
         ld_reg    <= 8'h00;
         pa_reg    <= 16'h0000;
         pend_reg  <= 1'b0;
      end else begin
         awf_reg   <= awf_next;
         awa_reg   <= awa_next;
         wf_reg    <= wf_next;
         wd_reg    <= wd_next;
         wst_reg   <= wst_next;
         bv_reg    <= bv_next;
         br_reg    <= br_next;
         rv_reg    <= rv_next;
         rr_reg    <= rr_next;
         rd_reg    <= rd_next;
         mode_reg  <= mode_next;
         win_reg   <= win_next;
         rwwb_reg  <= rwwb_next;
         irqen_reg <= irqen_next;
         irq_reg   <= irq_next;
         lv_reg    <= lv_next;
         ld_reg    <= ld_next;
         pa_reg    <= pa_next;
         pend_reg  <= pend_next;
      end
   end

   assign s_axi_awready = !awf_reg;
   assign s_axi_wready  = !wf_reg;
   assign s_axi_bvalid  = bv_reg;
   assign s_axi_bresp   = br_reg;
   assign s_axi_arready = !rv_reg;
   assign s_axi_rvalid  = rv_reg;
   assign s_axi_rresp   = rr_reg;
   assign s_axi_rdata   = rd_reg;
   assign pm_rd_addr    = pa_reg;
   assign lpm_valid     = lv_reg;
   assign lpm_data      = ld_reg;
   assign irq_req       = irq_reg;

   store_window_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      $rose(prog_busy) |-> $past(insn_store_pgm) && $past(win_reg) inside {[3'h1:3'h4]})
      else $error("lock write started outside store window");

   eep_prog_block_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (insn_store_pgm && eeprom_write_busy) |=> !$rose(prog_busy))
      else $error("lock write started during eeprom write");

   eep_read_block_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (insn_load_pgm && eeprom_write_busy) |=> !lv_reg ##1 lv_reg && ld_reg == $past(pm_rd_data))
      else $error("fuse or lock read during eeprom write");

   window_expiry_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (ctrl_wr && wd_reg[0] && !prog_busy) |=> (mode_reg != 6'h00)
         ##[1:4] (mode_reg == 6'h00 || (ctrl_wr && wd_reg[0])))
      else $error("command bits did not clear within four cycles");

   lock_readout_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (special_hit && insn_zptr == 16'h0001) |=> lv_reg && ld_reg == {2'b11, $past(lock_bits)})
      else $error("lock byte readout wrong");

   ext_fuse_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (special_hit && insn_zptr == 16'h0002) |=> ld_reg[7:4] == 4'hF && ld_reg[3:0] == $past(extended_fuse_byte))
      else $error("extended fuse readout wrong");

   rww_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      rww_prog_busy |=> rwwb_reg)
      else $error("rww busy flag dropped while section busy");

   irq_level_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (irqen_reg && !en_vis) [*2] |-> irq_reg)
      else $error("interrupt request not held while enable clear");

   ordinary_read_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (insn_load_pgm && mode_reg == 6'h00) |=> pa_reg == $past(insn_zptr) ##1 lv_reg)
      else $error("ordinary program read not performed");

endmodule

// ---- tb/slfa_cpu_model.sv ----
`timescale 1ns/1ps
module slfa_cpu_model (
   input  wire logic        core_clk,
   input  wire logic [15:0] pm_rd_addr,
   input  wire logic        lpm_valid,
   input  wire logic [7:0]  lpm_data,
   output logic             insn_store_pgm,
   output logic             insn_load_pgm,
   output logic [15:0]      insn_zptr,
   output logic [7:0]       low_working_register,
   output logic [7:0]       pm_rd_data
);
   // program memory contents follow the address
   assign pm_rd_data = pm_rd_addr[7:0] ^ pm_rd_addr[15:8] ^ 8'h5A;

   initial begin
      insn_store_pgm = 1'b0;
      insn_load_pgm = 1'b0;
      insn_zptr = 16'hFFFF;
      low_working_register = 8'hFF;
   end

   task automatic strobe(input logic st, input logic [15:0] z, input logic [7:0] d, input int gap);
      repeat (gap) @(posedge core_clk);
      insn_store_pgm <= st;
      insn_load_pgm <= ~st;
      insn_zptr <= z;
      low_working_register <= d;
      @(posedge core_clk);
      // operands are stale once the strobe is gone
      insn_store_pgm <= 1'b0;
      insn_load_pgm <= 1'b0;
      insn_zptr <= ~z;
      low_working_register <= ~d;
   endtask

   task automatic store(input logic [15:0] z, input logic [7:0] d, input int gap);
      strobe(1'b1, z, d, gap);
      @(posedge core_clk);
   endtask

   task automatic load(input logic [15:0] z, input int gap, output logic [7:0] q, output int lat);
      strobe(1'b0, z, 8'h00, gap);
      lat = 0;
      do begin
         @(posedge core_clk);
         lat++;
      end while (lpm_valid !== 1'b1 && lat < 4);
      q = lpm_data;
   endtask
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   localparam int   PROG = 20;
   localparam int   LIMIT = 4000;
   logic            core_clk;
   logic            arst_n = 1'b0;
   logic            por_n = 1'b0;
   logic [7:0]      awaddr = 8'h00;
   logic            awvalid = 1'b0;
   logic [31:0]     wdata = 32'h0;
   logic [3:0]      wstrb = 4'hF;
   logic            wvalid = 1'b0;
   logic [7:0]      araddr = 8'h00;
   logic            arvalid = 1'b0;
   logic            eeprom_write_busy = 1'b0;
   logic            rww_prog_busy = 1'b0;
   logic            awready, wready, bvalid, arready, rvalid, lpm_valid, irq_req;
   logic            store_s, load_s;
   logic [1:0]      bresp, rresp;
   logic [31:0]     rdata;
   logic [15:0]     zptr, pm_rd_addr;
   logic [7:0]      wreg, pm_rd_data, lpm_data;
   logic [5:0]      lock_bits;
   logic [5:0]      lock_exp = 6'h3F;
   int              fails = 0;
   int              total_checks = 0;
   int              cycles = 0;

   slfa_top #(.PROG_CYCLES(PROG)) i_slfa_top (.core_clk(core_clk), .arst_n(arst_n), .por_n(por_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(1'b1), .insn_store_pgm(store_s), .insn_load_pgm(load_s), .insn_zptr(zptr),
      .low_working_register(wreg), .eeprom_write_busy(eeprom_write_busy), .rww_prog_busy(rww_prog_busy),
      .fuse_low_byte(8'h62), .fuse_high_byte(8'hD9), .extended_fuse_byte(4'h9), .pm_rd_data(pm_rd_data),
      .pm_rd_addr(pm_rd_addr), .lpm_valid(lpm_valid), .lpm_data(lpm_data), .irq_req(irq_req),
      .lock_bits(lock_bits));

   slfa_cpu_model cpu (.core_clk(core_clk), .pm_rd_addr(pm_rd_addr), .lpm_valid(lpm_valid),
      .lpm_data(lpm_data), .insn_store_pgm(store_s), .insn_load_pgm(load_s), .insn_zptr(zptr),
      .low_working_register(wreg), .pm_rd_data(pm_rd_data));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic end_sim;
      if (fails == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         fails++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask

   function automatic logic [7:0] pm(input logic [15:0] z);
      return z[7:0] ^ z[15:8] ^ 8'h5A;
   endfunction

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge core_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge core_clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
   endtask

   task automatic cmd(input logic [7:0] v);
      logic [1:0] r;
      axi_wr(slfa_pkg::CTRL_OFS, {24'h0, v}, r);
      chk({30'h0, r}, {30'h0, slfa_pkg::RESP_OKAY});
   endtask

   task automatic rd_ctrl(output logic [31:0] d);
      logic [1:0] r;
      axi_rd(slfa_pkg::CTRL_OFS, d, r);
   endtask

   task automatic wait_idle(output int cyc);
      logic [31:0] d;
      int          t0;
      int          n;
      t0 = cycles;
      n = 0;
      do begin
         rd_ctrl(d);
         n++;
      end while (d[0] !== 1'b0 && n < 200);
      cyc = cycles - t0;
   endtask

   task automatic t_reset;
      logic [31:0] d;
      logic [1:0]  r;
      rd_ctrl(d);
      chk(d, 32'h0);
      axi_rd(slfa_pkg::LOCK_VIEW_OFS, d, r);
      chk(d, 32'hFF);
      axi_rd(8'h08, d, r);
      chk({30'h0, r}, {30'h0, slfa_pkg::RESP_SLVERR});
      // byte 0 not strobed: write must have no effect
      wstrb <= 4'hE;
      axi_wr(slfa_pkg::CTRL_OFS, 32'h00000081, r);
      wstrb <= 4'hF;
      chk({30'h0, r}, {30'h0, slfa_pkg::RESP_OKAY});
      rd_ctrl(d);
      chk(d, 32'h0);
   endtask

   task automatic t_readout;
      logic [15:0] zt [5] = '{slfa_pkg::Z_FUSE_LOW, slfa_pkg::Z_LOCK, slfa_pkg::Z_FUSE_EXT,
                              slfa_pkg::Z_FUSE_HIGH, 16'h0005};
      logic [7:0]  et [5] = '{8'h62, 8'hFF, 8'hF9, 8'hD9, 8'hFF};
      logic [31:0] d;
      logic [7:0]  q;
      int          lat;
      for (int i = 0; i < 5; i++) begin
         cmd(8'h09);
         cpu.load(zt[i], 0, q, lat);
         chk({24'h0, q}, {24'h0, et[i]});
         chk(32'(lat), 32'd1);
         rd_ctrl(d);
         chk({26'h0, d[5:0]}, 32'h0);
      end
      cmd(8'h09);
      cpu.load(slfa_pkg::Z_FUSE_LOW, 1, q, lat);
      chk({24'h0, q}, 32'h62);
      cmd(8'h09);
      cpu.load(slfa_pkg::Z_FUSE_LOW, 2, q, lat);
      chk({24'h0, q}, {24'h0, pm(16'h0)});
      chk(32'(lat), 32'd2);
      cmd(8'h09);
      cpu.store(slfa_pkg::Z_LOCK, 8'hC0, 3);
      repeat (2) @(posedge core_clk);
      rd_ctrl(d);
      chk({31'h0, d[0]}, 32'h0);
      chk({26'h0, lock_bits}, {26'h0, lock_exp});
   endtask

   task automatic t_restart;
      logic [7:0] q;
      int         lat;
      cmd(8'h09);
      cmd(8'h09);
      cpu.load(slfa_pkg::Z_LOCK, 1, q, lat);
      chk(32'(lat), 32'd1);
   endtask

   task automatic t_eeprom;
      logic [31:0] d;
      logic [7:0]  q;
      int          lat;
      eeprom_write_busy <= 1'b1;
      cmd(8'h09);
      cpu.store(slfa_pkg::Z_LOCK, 8'hC0, 0);
      repeat (4) @(posedge core_clk);
      rd_ctrl(d);
      chk({31'h0, d[0]}, 32'h0);
      chk({26'h0, lock_bits}, {26'h0, lock_exp});
      cmd(8'h09);
      cpu.load(slfa_pkg::Z_LOCK, 0, q, lat);
      chk({24'h0, q}, {24'h0, pm(slfa_pkg::Z_LOCK)});
      eeprom_write_busy <= 1'b0;
   endtask

   task automatic t_lockwr;
      logic [31:0] d;
      logic [1:0]  r;
      logic [7:0]  q;
      int          lat;
      int          cyc;
      cmd(8'h09);
      cpu.store(slfa_pkg::Z_LOCK, 8'hF6, 2);
      cpu.load(16'h0C10, 0, q, lat);
      chk({24'h0, q}, {24'h0, pm(16'h0C10)});
      wait_idle(cyc);
      chk({31'h0, cyc >= PROG - 2 && cyc <= PROG + 8}, 32'h1);
      lock_exp = 6'h36;
      chk({26'h0, lock_bits}, {26'h0, lock_exp});
      cmd(8'h09);
      cpu.load(slfa_pkg::Z_LOCK, 0, q, lat);
      chk({24'h0, q}, 32'hF6);
      axi_rd(slfa_pkg::LOCK_VIEW_OFS, d, r);
      chk(d, 32'hF6);
      cmd(8'h09);
      cpu.store(slfa_pkg::Z_LOCK, 8'hDF, 0);
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      wait_idle(cyc);
      lock_exp = 6'h16;
      chk({26'h0, lock_bits}, {26'h0, lock_exp});
   endtask

   task automatic t_irq;
      cmd(8'h80);
      @(posedge core_clk);
      chk({31'h0, irq_req}, 32'h1);
      cmd(8'h89);
      @(posedge core_clk);
      chk({31'h0, irq_req}, 32'h0);
      repeat (6) @(posedge core_clk);
      chk({31'h0, irq_req}, 32'h1);
      cmd(8'h00);
   endtask

   task automatic t_rww;
      logic [31:0] d;
      rww_prog_busy <= 1'b1;
      @(posedge core_clk);
      rww_prog_busy <= 1'b0;
      rd_ctrl(d);
      chk({31'h0, d[slfa_pkg::RWW_BUSY_BIT]}, 32'h1);
      cmd({2'h0, slfa_pkg::CMD_RWW_REEN});
      cpu.store(16'h0000, 8'h00, 0);
      rd_ctrl(d);
      chk({31'h0, d[slfa_pkg::RWW_BUSY_BIT]}, 32'h0);
   endtask

   initial begin
      repeat (3) @(posedge core_clk);
      arst_n <= 1'b1;
      por_n <= 1'b1;
      @(posedge core_clk);
      t_reset();
      t_readout();
      t_restart();
      t_eeprom();
      t_lockwr();
      t_irq();
      t_rww();
      end_sim();
   end
endmodule
